// *** include/intr_pkg.sv ***
// Package with constants and carrier types for the bus interrupt and power-fail block.
package intr_pkg;

  // ==========================================================================
  // Clock and timing constants
  // ==========================================================================
  localparam int unsigned CLK_NS = 40;  // Period of pclk in ns.
  localparam int unsigned FREE_PERIOD_NS = 90;  // Arbitration free clock period.
  localparam int unsigned FREE_PULSE_NS = 30;  // Arbitration free clock pulse width.
  localparam int unsigned FREE_DIV = (FREE_PERIOD_NS + CLK_NS - 1) / CLK_NS;  // Least time, rounded up.
  localparam int unsigned RESTART_NS = 75;  // Least time from restart to T3.
  localparam int unsigned RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PASSIVE_NS = 90;  // Least delay after acknowledge release.
  localparam int unsigned PASSIVE_CYC = (PASSIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PF_TIMER_US = 2000;  // Power-fail timer, 2 ms.
  localparam int unsigned PF_TIMER_CYC = PF_TIMER_US * 1000 / CLK_NS;
  localparam int unsigned DCLO_PULSE_NS = 1000;  // Generated DC-low pulse, 1 us.
  localparam int unsigned DCLO_PULSE_CYC = DCLO_PULSE_NS / CLK_NS;  // Longest time, rounded down.

  // ==========================================================================
  // Microprogram constants
  // ==========================================================================
  localparam logic [2:0] MSC_SAMPLE = 3'h6;  // Control field value that samples requests.
  localparam logic [3:0] BEN_PREFETCH = 4'hc;  // Branch enable code before fetch (12).
  localparam logic [8:0] MICRO_ADDRESS_FIELD_PREFETCH = 9'h0f0;  // Micro-address before fetch (240).
  localparam logic [8:0] MICRO_ADDRESS_FIELD_INIT = 9'h080;  // Forced micro-address on DC-low (200 octal).

  // ==========================================================================
  // Register layout
  // ==========================================================================
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;  // Microsequence inputs.
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;  // Flags and handshake state.
  localparam logic [31:0] ADDR_VECT = 32'h0000_0008;  // Latched vector.
  localparam logic [31:0] ADDR_CLR = 32'h0000_000c;  // Write one to clear flags.
  localparam int unsigned TMR_W = 17;  // Width of the power-fail timer.

  // Timing states of the main timing generator.
  typedef enum logic [2:0] {TS_T1, TS_T2, TS_T3, TS_T4, TS_T5} tstate_e;

  // Break microsequence outcome.
  typedef enum logic [1:0] {BR_NONE, BR_FETCH, BR_SERVICE, BR_RETURN} brk_e;

  // Bus-side grant, handshake and power outputs.
  typedef struct packed {
    logic [3:0] grant;  // Grant levels 7..4, bit 3 is level 7.
    logic slave_sync;  // Slave sync asserted by the processor.
    logic dclo_out;  // Generated DC-low pulse.
    logic init_out;  // Bus init.
  } bus_out_s;

  // Microsequence status seen by software.
  typedef struct packed {
    logic interrupt_received_flag;
    logic power_down_flag;
    logic power_up_flag;
    logic power_fail_clear_ff;
    logic passive_flag;
    logic timing_running;
    logic grant_enable;
    logic [3:0] level_honour;
  } status_s;

endpackage

// *** src/free_pulse.sv ***
// Arbitration free clock: one-cycle strobe every divided period.
`timescale 1ns/100ps
module free_pulse import intr_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Strobe out.
  output logic strobe
);

  logic [3:0] cnt_q;  // Divider count.

  // Count down the period and strobe at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'h0) begin
      cnt_q <= 4'(FREE_DIV - 1);
    end else begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign strobe = (cnt_q == 4'h0);  // One-cycle pulse, shorter than a period.

endmodule

// *** src/bus_intr_pf.sv ***
// Bus interrupt grant, passive release and power-fail sequencing with APB registers.
//
// Overview of operation
// - Sample requests at TS3 when control equals six.
// - Honour highest outranking bus request level.
// - Prefetch cycle branches fetch or break entry.
// - Stop timing in T2 while honouring bus level.
// - Grant request follows external request, service done.
// - Grant enable needs all grants done, delayed clear.
// - Acknowledge, then delayed acknowledge clears grant.
// - Release clears acknowledge, then delayed acknowledge.
// - Interrupt restarts timing; T3 latches vector later.
// - T4 clears external request; then grant enabled.
// - Slave sync at T3, dropped after interrupt removal.
// - Interrupt flag steers break into service flows.
// - Passive flag clocked by delayed acknowledge fall.
// - Passive without interrupt returns to program.
// - Memory power lines act like bus lines.
// - AC-low sets power-down flag; arbitration honours it.
// - Block strobe and T3 strobe set power-fail clear.
// - Power-fail clear resets flags, times DC-low pulse.
// - DC-low inits, forces address, stops timing.
// - Own DC-low pulse sets power-up flag.
// - Arbitration logic runs from periodic free strobe.
// - At most one grant at a time.
// - No grant while acknowledge asserted.
`timescale 1ns/100ps
module bus_intr_pf import intr_pkg::*; #(
  parameter int unsigned PF_CYC = PF_TIMER_CYC  // Power-fail timer length in cycles.
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus request and power pins.
  input wire logic [3:0] bus_request,
  input wire logic npr_request,
  input wire logic bus_ack,
  input wire logic bus_intr,
  input wire logic bus_busy,
  input wire logic [15:0] bus_data,
  input wire logic bus_aclo,
  input wire logic bus_dclo,
  input wire logic main_aclo,
  input wire logic main_dclo,
  // Internal trap inputs that outrank power fail.
  input wire logic parity_trap,
  input wire logic mm_trap,
  input wire logic stack_limit_warning,
  // Outputs to the bus.
  output bus_out_s bus_out,
  output logic [8:0] micro_address_field
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int SW = 28;
  logic [SW-1:0] s1_q, s2_q;  // Two-stage synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {bus_request, npr_request, bus_ack, bus_intr, bus_busy, bus_data, bus_aclo, bus_dclo,
               main_aclo, main_dclo};
      s2_q <= s1_q;
    end
  end
  logic [3:0] req_s;
  logic npr_s, ack_s, intr_s, bbsy_s, aclo_s, dclo_in_s;
  logic [15:0] data_s;
  assign {req_s, npr_s, ack_s, intr_s, bbsy_s, data_s} = s2_q[SW-1:4];
  assign aclo_s = s2_q[3] | s2_q[1];  // Both AC-low sources act alike.
  assign dclo_in_s = s2_q[2] | s2_q[0];  // Both DC-low sources act alike.

  // ==========================================================================
  // Registers written by software
  // ==========================================================================
  logic [2:0] msc_q;  // Microsequence control field.
  logic [3:0] ben_q;  // Branch enable code.
  logic [8:0] micro_address_field_q;  // Micro-address field of current cycle.
  logic svc_last_q;  // Last service step reached.
  logic abort_pend_q;  // Aborts pending.
  logic brk_ack_q;  // Break acknowledge at TS3.
  logic [15:0] vector_q;  // Latched vector.
  brk_e brk_q;  // Break branch decision.
  logic wr_en, rd_en;
  logic rd_wait_q;  // Read access has spent its one wait state.
  assign wr_en = psel & penable & pwrite;
  // Read data is loaded in the first access cycle so that it stands when pready is high.
  assign rd_en = psel & penable & ~pwrite & ~rd_wait_q;
  assign pready = ~(psel & penable & ~pwrite) | rd_wait_q;  // Writes take no wait state, reads one.

  // One wait state for every read access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= rd_en;
    end
  end
  assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STAT) &
                   (paddr != ADDR_VECT) & (paddr != ADDR_CLR);

  // Capture control writes from software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msc_q <= '0;
      ben_q <= '0;
      micro_address_field_q <= '0;
      svc_last_q <= 1'b0;
      abort_pend_q <= 1'b0;
      brk_ack_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      msc_q <= pwdata[2:0];
      ben_q <= pwdata[7:4];
      micro_address_field_q <= pwdata[16:8];
      svc_last_q <= pwdata[20];
      abort_pend_q <= pwdata[21];
      brk_ack_q <= pwdata[22];
    end else begin
      brk_ack_q <= 1'b0;  // Single-shot strobes.
      svc_last_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Main timing generator
  // ==========================================================================
  tstate_e ts_q;  // Current timing state.
  logic running_q;  // Timing clock runs.
  logic [1:0] rst_cnt_q;  // Delay from restart to T3.
  logic free;  // Arbitration strobe.
  logic stop_t2, restart, init_act, passive_q, wait_cycle;
  free_pulse u_free (.pclk(pclk), .presetn(presetn), .strobe(free));

  // Advance timing states, stop in T2 and restart after the set delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q <= TS_T1;
      running_q <= 1'b1;
      rst_cnt_q <= '0;
    end else if (init_act) begin
      ts_q <= TS_T1;  // Timing stopped and cleared.
      running_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (!running_q) begin
      if (rst_cnt_q != 2'h0) begin
        rst_cnt_q <= rst_cnt_q - 2'h1;
        if (rst_cnt_q == 2'h1) begin
          ts_q <= TS_T3;  // T3 no sooner than the restart delay.
          running_q <= 1'b1;
        end
      end else if (restart) begin
        rst_cnt_q <= 2'(RESTART_CYC);
      end else if (ts_q != TS_T2) begin
        ts_q <= TS_T1;
        running_q <= 1'b1;
      end
    end else if (stop_t2) begin
      running_q <= 1'b0;  // Halt in T2 while honouring.
    end else begin
      ts_q <= (ts_q == TS_T5) ? TS_T1 : tstate_e'(ts_q + 3'h1);
    end
  end

  // ==========================================================================
  // Priority arbitration
  // ==========================================================================
  logic [3:0] prio_q;  // Priority flip-flops for bus levels.
  logic pwr_pend_q;  // Power-down flag sampled into priority.
  logic [3:0] level_honour;
  logic power_fail_honour, priority_sample_strobe, any_request_true, power_fail_clear_ff_q, power_down_flag_q;
  assign priority_sample_strobe = running_q & (ts_q == TS_T3) & (msc_q == MSC_SAMPLE);

  // Sample the four bus request lines near the end of an instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= '0;
      pwr_pend_q <= 1'b0;
    end else if (power_fail_clear_ff_q || init_act) begin
      prio_q <= '0;
      pwr_pend_q <= 1'b0;
    end else if (priority_sample_strobe) begin
      prio_q <= req_s;
      pwr_pend_q <= power_down_flag_q;
    end
  end

  // Power fail outranks bus levels unless an internal trap is up.
  assign power_fail_honour = pwr_pend_q & ~parity_trap & ~mm_trap & ~stack_limit_warning;
  // Highest level wins, one-hot.
  assign level_honour = power_fail_honour ? 4'h0 :
                        prio_q[3] ? 4'h8 : prio_q[2] ? 4'h4 : prio_q[1] ? 4'h2 : prio_q[0] ? 4'h1 : 4'h0;
  assign any_request_true = power_fail_honour | (|level_honour);

  // ==========================================================================
  // Break sequence branch
  // ==========================================================================
  logic wait_q;  // In the interrupt wait cycle.
  logic interrupt_received_flag_q;  // Interrupt received flag.
  logic ext_q, grant_q, ack_q, dack_q, clrbg_q, ssyn_q;
  assign wait_cycle = wait_q;
  assign stop_t2 = wait_cycle & (ts_q == TS_T2) & (|level_honour);

  // Decide the branch of the prefetch cycle and the break exit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 1'b0;
      brk_q <= BR_NONE;
    end else if (init_act) begin
      wait_q <= 1'b0;
      brk_q <= BR_NONE;
    end else if (wait_q && running_q && ts_q == TS_T5) begin
      wait_q <= 1'b0;
      // Interrupt or power fail goes to service, otherwise return.
      brk_q <= (interrupt_received_flag_q || power_fail_honour) ? BR_SERVICE : BR_RETURN;
    end else if (ben_q == BEN_PREFETCH && micro_address_field_q == MICRO_ADDRESS_FIELD_PREFETCH && ts_q == TS_T5) begin
      wait_q <= any_request_true;  // Break entry cancels prior bus start.
      brk_q <= any_request_true ? BR_NONE : BR_FETCH;
    end
  end

  // ==========================================================================
  // Grant arbitration on the free strobe
  // ==========================================================================
  logic grant_enable, dack_prev_q, pass_d_q;
  logic [1:0] rel_cnt_q;  // Cycles since acknowledge release.
  // Service complete when all grants done and delayed ack clear.
  assign grant_enable = ~clrbg_q & ~dack_q;

  // External request, grant request, acknowledge and clear-grant flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
      grant_q <= 1'b0;
      ack_q <= 1'b0;
      dack_q <= 1'b0;
      clrbg_q <= 1'b0;
    end else if (init_act) begin
      ext_q <= 1'b0;
      grant_q <= 1'b0;
      ack_q <= 1'b0;
      dack_q <= 1'b0;
      clrbg_q <= 1'b0;
    end else if (free) begin
      if (wait_cycle && ts_q == TS_T2 && (|level_honour)) begin
        ext_q <= 1'b1;
      end else if (ts_q == TS_T4) begin
        ext_q <= 1'b0;
      end
      ack_q <= ack_s;  // Set and cleared on first strobe.
      dack_q <= ack_q;  // Delayed copy one strobe later.
      if (grant_q && ack_q) begin
        grant_q <= 1'b0;  // Toggled off as delayed ack sets.
        clrbg_q <= 1'b1;  // Negates grant enable.
      end else if (ext_q && !grant_q && !npr_s && grant_enable && !ack_s) begin
        grant_q <= 1'b1;
      end else if (!ext_q && clrbg_q) begin
        clrbg_q <= 1'b0;  // Grant enable returns after T4.
      end
    end
  end

  // Passive release: clocked by delayed acknowledge falling, after the minimum wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dack_prev_q <= 1'b0;
      pass_d_q <= 1'b0;
      rel_cnt_q <= '0;
      passive_q <= 1'b0;
    end else begin
      dack_prev_q <= dack_q;
      rel_cnt_q <= ack_s ? 2'h0 : (rel_cnt_q == 2'(PASSIVE_CYC) ? rel_cnt_q : rel_cnt_q + 2'h1);
      if (dack_prev_q && !dack_q && rel_cnt_q >= 2'(PASSIVE_CYC)) begin
        pass_d_q <= clrbg_q & ~interrupt_received_flag_q;
      end else if (passive_q) begin
        pass_d_q <= 1'b0;
      end
      passive_q <= pass_d_q & ~bbsy_s & ~running_q;  // Restarts timing.
    end
  end

  assign restart = intr_s | passive_q;

  // Vector latch, slave sync and interrupt flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_q <= '0;
      ssyn_q <= 1'b0;
      interrupt_received_flag_q <= 1'b0;
    end else begin
      if (wait_cycle && intr_s && rst_cnt_q == 2'h1) begin
        vector_q <= data_s;
        ssyn_q <= 1'b1;
      end else if (!intr_s) begin
        ssyn_q <= 1'b0;  // Drop after interrupt removed.
      end
      if (wait_cycle && intr_s) begin
        interrupt_received_flag_q <= 1'b1;
      end else if (wr_en && paddr == ADDR_CLR && pwdata[0]) begin
        interrupt_received_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Power-down and power-up sequencing
  // ==========================================================================
  logic block_q, blk_strobe_q, puf_q, dclo_pulse_q;
  logic [TMR_W-1:0] tmr_q;  // Power-fail timer.
  logic [5:0] pulse_q;  // DC-low pulse width counter.
  assign init_act = dclo_in_s | dclo_pulse_q;

  // Power-down flag, block strobe and power-fail clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag_q <= 1'b0;
      block_q <= 1'b0;
      blk_strobe_q <= 1'b0;
      power_fail_clear_ff_q <= 1'b0;
    end else begin
      if (power_fail_clear_ff_q) begin
        power_down_flag_q <= 1'b0;
        block_q <= 1'b1;
      end else if (aclo_s && !block_q) begin
        power_down_flag_q <= 1'b1;
      end else if (wr_en && paddr == ADDR_CLR && pwdata[1]) begin
        block_q <= 1'b0;
      end
      if (brk_ack_q) begin
        blk_strobe_q <= 1'b1;
      end else if (power_fail_clear_ff_q) begin
        blk_strobe_q <= 1'b0;
      end
      power_fail_clear_ff_q <= svc_last_q & ~abort_pend_q & blk_strobe_q & power_fail_honour;
    end
  end

  // Timer then a fixed-width DC-low pulse; the pulse sets the power-up flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= '0;
      pulse_q <= '0;
      dclo_pulse_q <= 1'b0;
      puf_q <= 1'b0;
    end else begin
      if (power_fail_clear_ff_q) begin
        tmr_q <= TMR_W'(PF_CYC);
      end else if (tmr_q != '0) begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
      if (tmr_q == TMR_W'(1)) begin
        pulse_q <= 6'(DCLO_PULSE_CYC);
        dclo_pulse_q <= 1'b1;
      end else if (pulse_q != 6'h0) begin
        pulse_q <= pulse_q - 6'h1;
        dclo_pulse_q <= (pulse_q != 6'h1);
      end
      if (dclo_pulse_q || dclo_in_s) begin
        puf_q <= 1'b1;
      end else if (wr_en && paddr == ADDR_CLR && pwdata[2]) begin
        puf_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Outputs and read data
  // ==========================================================================
  status_s stat;
  always_comb begin
    stat = '{interrupt_received_flag: interrupt_received_flag_q, power_down_flag: power_down_flag_q, power_up_flag: puf_q,
             power_fail_clear_ff: power_fail_clear_ff_q, passive_flag: pass_d_q, timing_running: running_q,
             grant_enable: grant_enable, level_honour: level_honour};
  end

  // Grant gated by grant request; at most one level, none during acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_out <= '0;
      micro_address_field <= '0;
      prdata <= '0;
    end else begin
      bus_out.grant <= (grant_q && !ack_s) ? level_honour : 4'h0;
      bus_out.slave_sync <= ssyn_q;
      bus_out.dclo_out <= dclo_pulse_q;
      bus_out.init_out <= init_act;
      micro_address_field <= init_act ? MICRO_ADDRESS_FIELD_INIT : micro_address_field_q;
      if (rd_en) begin
        case (paddr)
          ADDR_CTRL: prdata <= {9'h0, brk_ack_q, abort_pend_q, svc_last_q, 3'h0, micro_address_field_q, ben_q, 1'b0, msc_q};
          ADDR_STAT: prdata <= {16'h0, ts_q, brk_q, stat};
          ADDR_VECT: prdata <= {16'h0, vector_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_grant_onehot: assert property (@(posedge pclk) disable iff (!presetn) $onehot0(bus_out.grant))
    else $error("more than one grant level");
  a_no_grant_ack: assert property (@(posedge pclk) disable iff (!presetn) ack_s |=> bus_out.grant == 4'h0)
    else $error("grant during acknowledge");
  a_honour_onehot: assert property (@(posedge pclk) disable iff (!presetn) $onehot0(level_honour))
    else $error("honour not one-hot");
  a_stop_in_t2: assert property (@(posedge pclk) disable iff (!presetn) stop_t2 && running_q |=> !running_q)
    else $error("timing did not stop");
  a_dack_follow: assert property (@(posedge pclk) disable iff (!presetn) $rose(dack_q) |-> ack_q)
    else $error("delayed ack without ack");
  a_pf_clears: assert property (@(posedge pclk) disable iff (!presetn) power_fail_clear_ff_q |=> !power_down_flag_q && block_q)
    else $error("power-fail clear effect missing");
  a_init_addr: assert property (@(posedge pclk) disable iff (!presetn) init_act |=> micro_address_field == MICRO_ADDRESS_FIELD_INIT)
    else $error("init address not forced");
  a_puf_set: assert property (@(posedge pclk) disable iff (!presetn) dclo_pulse_q |=> puf_q)
    else $error("power-up flag not set");
  a_sample_prio: assert property (@(posedge pclk) disable iff (!presetn)
    priority_sample_strobe && !power_fail_clear_ff_q && !init_act |=> prio_q == $past(req_s))
    else $error("priority not sampled");
  a_return_path: assert property (@(posedge pclk) disable iff (!presetn)
    wait_q && running_q && ts_q == TS_T5 && !interrupt_received_flag_q && !power_fail_honour && !init_act |=> brk_q == BR_RETURN)
    else $error("break did not take return path");
  c_grant: cover property (@(posedge pclk) disable iff (!presetn) |bus_out.grant);
  c_vector: cover property (@(posedge pclk) disable iff (!presetn) $rose(ssyn_q));
  c_passive: cover property (@(posedge pclk) disable iff (!presetn) $rose(passive_q));
  c_dclo: cover property (@(posedge pclk) disable iff (!presetn) $rose(dclo_pulse_q));

endmodule

// *** bench/bus_dev_model.sv ***
// Behavioural model of an interrupting bus device.
`timescale 1ns/100ps
module bus_dev_model import intr_pkg::*; (
  // Clock, reset and bench controls.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] level,
  input wire logic passive,
  input wire logic [15:0] vector,
  // Processor side.
  input wire bus_out_s bus_out,
  // Device pins.
  output logic [3:0] bus_request,
  output logic bus_ack,
  output logic bus_intr,
  output logic bus_busy,
  output logic [15:0] bus_data
);
  logic [1:0] st_q;  // Transaction step of the device.
  // Request, take the grant, then interrupt or release passively; idle data lines toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {st_q, bus_request, bus_ack, bus_intr, bus_busy} <= '0;
      bus_data <= 16'h0000;
    end else begin
      bus_data <= ~bus_data;
      case (st_q)
        2'h0: begin
          bus_request <= level;
          if (|bus_out.grant) begin
            {bus_ack, bus_busy, st_q} <= {2'b11, 2'h1};
            bus_request <= 4'h0;
          end
        end
        2'h1: if (bus_out.grant == 4'h0) begin  // Vector and interrupt come before release.
          bus_intr <= !passive;
          bus_data <= passive ? ~bus_data : vector;
          st_q <= 2'h2;
        end
        2'h2: begin
          {bus_ack, bus_busy} <= 2'b00;
          bus_data <= bus_intr ? vector : ~bus_data;
          if (!bus_intr || bus_out.slave_sync) begin  // Slave sync ends the interrupt.
            bus_intr <= 1'b0;
            st_q <= 2'h0;
          end
        end
        default: st_q <= 2'h0;
      endcase
    end
  end
endmodule

// *** bench/tb_bus_intr_pf.sv ***
// Self-checking testbench for the bus interrupt and power-fail block.
`timescale 1ns/100ps
module tb_bus_intr_pf import intr_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, passive = 0, pslverr, pready;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, err;
  logic [3:0] level = 0, bus_request, last_grant = 0;
  logic bus_ack, bus_intr, bus_busy, aclo = 0, dclo = 0, trap = 0;
  logic [15:0] bus_data, vector = 16'h01a4;
  logic [8:0] micro_address_field;
  bus_out_s bus_out;
  int n_errors = 0, tests_run = 0, n;
  localparam logic [31:0] CTRL_PRE = 32'h0000_f0c6;  // Sample field, prefetch code and address.
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (bus_out.grant !== 4'h0) last_grant <= bus_out.grant;
  bus_dev_model i_bus_dev_model (.pclk(pclk), .presetn(presetn), .level(level), .passive(passive),
    .vector(vector), .bus_out(bus_out), .bus_request(bus_request), .bus_ack(bus_ack),
    .bus_intr(bus_intr), .bus_busy(bus_busy), .bus_data(bus_data));
  bus_intr_pf #(.PF_CYC(100)) i_bus_intr_pf (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_request(bus_request), .npr_request(1'b0),
    .bus_ack(bus_ack), .bus_intr(bus_intr), .bus_busy(bus_busy), .bus_data(bus_data),
    .bus_aclo(1'b0), .bus_dclo(dclo), .main_aclo(aclo), .main_dclo(dclo), .parity_trap(trap),
    .mm_trap(1'b0), .stack_limit_warning(1'b0), .bus_out(bus_out),
    .micro_address_field(micro_address_field));
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge where pready is high.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk) penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin n_errors++; final_report(); end
    rd = prdata;
    err = {31'h0, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // Poll the status word until the masked field matches.
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if ((rd & m) === v) break;
    end
    check(rd & m, v);
  endtask
  task automatic s_reset();
    check({25'h0, bus_out}, 32'h0);
    apb(1'b0, 32'h0000_0010, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
  endtask
  task automatic s_fetch();
    apb(1'b1, ADDR_CTRL, CTRL_PRE);
    wait_stat(32'h0000_1800, 32'h0000_0800);
  endtask
  task automatic s_intr();
    level <= 4'b0110;  // Level 6 outranks level 5.
    wait_stat(32'h0000_0020, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_f006);  // No further prefetch, so the break outcome stands.
    wait_stat(32'h0000_1c00, 32'h0000_1400);
    level <= 4'h0;
    check({28'h0, last_grant}, 32'h0000_0004);
    apb(1'b0, ADDR_VECT, 32'h0);
    check(rd, {16'h0, vector});
    wait_stat(32'h0000_0010, 32'h0000_0010);
    apb(1'b1, ADDR_CLR, 32'h0000_0001);
  endtask
  task automatic s_passive();
    apb(1'b1, ADDR_CTRL, CTRL_PRE);
    {passive, level} <= {1'b1, 4'b0001};
    wait_stat(32'h0000_0020, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_f006);
    wait_stat(32'h0000_1c00, 32'h0000_1800);
    check({28'h0, last_grant}, 32'h0000_0001);
    level <= 4'h0;
  endtask
  task automatic s_power();
    @(posedge pclk) aclo <= 1'b1;
    wait_stat(32'h0000_0200, 32'h0000_0200);
    apb(1'b1, ADDR_CTRL, 32'h0040_0000);
    apb(1'b1, ADDR_CTRL, 32'h0010_0000);
    wait_stat(32'h0000_0200, 32'h0000_0000);
    for (n = 0; n < 300 && bus_out.dclo_out !== 1'b1; n++) @(posedge pclk);
    for (n = 0; n < 300 && bus_out.dclo_out === 1'b1; n++) @(posedge pclk);
    check(n, DCLO_PULSE_CYC);
    @(posedge pclk) dclo <= 1'b1;
    repeat (4) @(posedge pclk);
    check({22'h0, bus_out.init_out, micro_address_field}, {23'h1, MICRO_ADDRESS_FIELD_INIT});
    @(posedge pclk) dclo <= 1'b0;
    repeat (4) @(posedge pclk) aclo <= 1'b0;
    wait_stat(32'h0000_0100, 32'h0000_0100);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_fetch();
    s_intr();
    s_passive();
    s_power();
    final_report();
  end
endmodule
